// ---- spid_decoder.sv ----
// Instruction decoder of the serial programming access layer
`timescale 1ns/1ps
`default_nettype none
module spid_decoder (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Link clock and receive side of the physical layer
    input  wire logic        linkClk,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxBreak,
    input  wire logic        rxFault,
    input  wire logic        txCollision,
    // Transmit side of the physical layer
    output logic             txValid,
    output logic [7:0]       txData,
    input  wire logic        txReady,
    output logic [2:0]       guardTime,
    // Data space bus on the system clock
    output logic             dsValid,
    output logic             dsWrite,
    output logic             dsIoSpace,
    output logic [15:0]      dsAddr,
    output logic [7:0]       dsWdata,
    input  wire logic        dsReady,
    input  wire logic [7:0]  dsRdata,
    // Memory controller access
    output logic             nvmEnable
);

    // ========================================
    // Opcode decoding
    function automatic logic isLoad(input logic [7:0] op);
        return (op | spid_pkg::OP_INC_BIT) == spid_pkg::OP_LOAD_INC;
    endfunction

    function automatic logic isStore(input logic [7:0] op);
        return (op | spid_pkg::OP_INC_BIT) == spid_pkg::OP_STORE_INC;
    endfunction

    function automatic logic isPtrW(input logic [7:0] op);
        return (op | spid_pkg::OP_PTR_BIT) == spid_pkg::OP_PTR_ANY;
    endfunction

    function automatic logic isIoRd(input logic [7:0] op);
        return (op & spid_pkg::IO_MASK) == spid_pkg::IO_RD;
    endfunction

    function automatic logic isIoWr(input logic [7:0] op);
        return (op & spid_pkg::IO_MASK) == spid_pkg::IO_WR;
    endfunction

    function automatic logic isCsRd(input logic [7:0] op);
        return (op & spid_pkg::CS_MASK) == spid_pkg::CS_RD;
    endfunction

    function automatic logic isCsWr(input logic [7:0] op);
        return (op & spid_pkg::CS_MASK) == spid_pkg::CS_WR;
    endfunction

    function automatic logic [15:0] ioAddr(input logic [7:0] op);
        return {10'h000, op[6:5], op[3:0]};
    endfunction

    // ========================================
    // Link domain state
    spid_pkg::spid_state_t state_reg, state_next;
    logic [7:0]  op_reg,    op_next;
    logic [3:0]  cnt_reg,   cnt_next;
    logic [63:0] key_reg,   key_next;
    logic [15:0] ptr_reg,   ptr_next;
    logic        memEn_reg, memEn_next;
    logic [2:0]  guard_reg, guard_next;
    logic        reqT_reg,  reqT_next;
    logic [15:0] addr_reg,  addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        wr_reg,    wr_next;
    logic        io_reg,    io_next;
    logic        txV_reg,   txV_next;
    logic [7:0]  txD_reg,   txD_next;
    logic        issue;
    logic        linkRstN;
    logic        ackTSync;

    // System domain state
    logic        reqTSync;
    logic        ackT_reg;
    logic        dsV_reg;
    logic        dsW_reg;
    logic        dsIo_reg;
    logic [15:0] dsA_reg;
    logic [7:0]  dsD_reg;
    logic [7:0]  rdata_reg;

    // ========================================
    // Named decode wires
    wire logic exc     = rxBreak | rxFault | txCollision;
    wire logic pending = reqT_reg != ackTSync;
    wire logic [3:0] csAddr = rxData[3:0];
    wire logic [7:0] statusByte =
        8'(memEn_reg) << spid_pkg::MEMEN_BIT;
    wire logic [7:0] cssRead =
        (csAddr == spid_pkg::CSS_STATUS)  ? statusByte :
        (csAddr == spid_pkg::CSS_PHYCTRL) ? {5'h00, guard_reg} :
        (csAddr == spid_pkg::CSS_IDENT)   ? spid_pkg::IDENT_CODE :
        8'h00;
    wire logic [7:0] csWrAddr = {4'h0, op_reg[3:0]};
    wire logic [63:0] keyShift = {rxData, key_reg[63:8]};

    // ========================================
    // Reset and level crossings
    // Reset reaches the link side through its own synchroniser;
    // clearing both stages while nrst is low keeps the release clean
    spid_sync uRstSync (
        .clk  (linkClk),
        .rstN (nrst),
        .d    (nrst),
        .q    (linkRstN)
    );

    spid_sync uReqSync (
        .clk  (clk),
        .rstN (nrst),
        .d    (reqT_reg),
        .q    (reqTSync)
    );

    spid_sync uAckSync (
        .clk  (linkClk),
        .rstN (linkRstN),
        .d    (ackT_reg),
        .q    (ackTSync)
    );

    // Enable is a slow level, two flops are enough
    spid_sync uEnSync (
        .clk  (clk),
        .rstN (nrst),
        .d    (memEn_reg),
        .q    (nvmEnable)
    );

    // ========================================
    // Instruction sequencer, next values
    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        cnt_next   = cnt_reg;
        key_next   = key_reg;
        ptr_next   = ptr_reg;
        memEn_next = memEn_reg;
        guard_next = guard_reg;
        addr_next  = addr_reg;
        wr_next    = wr_reg;
        io_next    = io_reg;
        txV_next   = txV_reg;
        txD_next   = txD_reg;
        issue      = 1'b0;
        // A faulty frame is never executed
        if (exc && state_reg != spid_pkg::ST_ERR) begin
            state_next = spid_pkg::ST_ERR;
            txV_next   = 1'b0;
        end else begin
            case (state_reg)
                spid_pkg::ST_IDLE: begin
                    if (rxValid) begin
                        op_next = rxData;
                        if (isLoad(rxData)) begin
                            issue      = 1'b1;
                            addr_next  = ptr_reg;
                            wr_next    = 1'b0;
                            io_next    = 1'b0;
                            state_next = spid_pkg::ST_BUS;
                        end else if (isIoRd(rxData)) begin
                            issue      = 1'b1;
                            addr_next  = ioAddr(rxData);
                            wr_next    = 1'b0;
                            io_next    = 1'b1;
                            state_next = spid_pkg::ST_BUS;
                        end else if (isCsRd(rxData)) begin
                            txD_next   = cssRead;
                            txV_next   = 1'b1;
                            state_next = spid_pkg::ST_SEND;
                        end else if (rxData == spid_pkg::OP_KEY) begin
                            cnt_next   = 4'h0;
                            state_next = spid_pkg::ST_KEY;
                        end else begin
                            state_next = spid_pkg::ST_OPND;
                        end
                    end
                end
                spid_pkg::ST_OPND: begin
                    if (rxValid) begin
                        state_next = spid_pkg::ST_IDLE;
                        if (isStore(op_reg)) begin
                            issue      = 1'b1;
                            addr_next  = ptr_reg;
                            wr_next    = 1'b1;
                            io_next    = 1'b0;
                            state_next = spid_pkg::ST_BUS;
                        end else if (isPtrW(op_reg)) begin
                            if (op_reg[0])
                                ptr_next[15:8] = rxData;
                            else
                                ptr_next[7:0] = rxData;
                        end else if (isIoWr(op_reg)) begin
                            issue      = 1'b1;
                            addr_next  = ioAddr(op_reg);
                            wr_next    = 1'b1;
                            io_next    = 1'b1;
                            state_next = spid_pkg::ST_BUS;
                        end else if (isCsWr(op_reg)) begin
                            if (csWrAddr == 8'(spid_pkg::CSS_STATUS) &&
                                !rxData[spid_pkg::MEMEN_BIT])
                                memEn_next = 1'b0;
                            if (csWrAddr == 8'(spid_pkg::CSS_PHYCTRL))
                                guard_next = rxData[2:0];
                        end
                    end
                end
                spid_pkg::ST_KEY: begin
                    if (rxValid) begin
                        key_next = keyShift;
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == spid_pkg::KEY_LAST) begin
                            state_next = spid_pkg::ST_IDLE;
                            if (keyShift == spid_pkg::KEY_VALUE)
                                memEn_next = 1'b1;
                        end
                    end
                end
                spid_pkg::ST_BUS: begin
                    if (!pending) begin
                        if (op_reg[2] &&
                            (isLoad(op_reg) || isStore(op_reg)))
                            ptr_next = ptr_reg + 16'h0001;
                        if (!wr_reg) begin
                            txD_next   = rdata_reg;
                            txV_next   = 1'b1;
                            state_next = spid_pkg::ST_SEND;
                        end else begin
                            state_next = spid_pkg::ST_IDLE;
                        end
                    end
                end
                spid_pkg::ST_SEND: begin
                    if (txReady) begin
                        txV_next   = 1'b0;
                        state_next = spid_pkg::ST_IDLE;
                    end
                end
                spid_pkg::ST_ERR: begin
                    txV_next = 1'b0;
                    // Wait out a bus access still in flight
                    if (rxBreak && !pending)
                        state_next = spid_pkg::ST_IDLE;
                end
                default: begin
                    state_next = spid_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign reqT_next  = issue ? ~reqT_reg : reqT_reg;
    assign wdata_next = issue ? rxData : wdata_reg;

    // ========================================
    // Link domain registers
    always_ff @(posedge linkClk) begin
        if (!linkRstN) begin
            state_reg <= spid_pkg::ST_IDLE;
            op_reg    <= 8'h00;
            cnt_reg   <= 4'h0;
            key_reg   <= 64'h0;
            ptr_reg   <= spid_pkg::PTR_RST;
            memEn_reg <= 1'b0;
            guard_reg <= spid_pkg::GUARD_RST;
            reqT_reg  <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
            wr_reg    <= 1'b0;
            io_reg    <= 1'b0;
            txV_reg   <= 1'b0;
            txD_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            op_reg    <= op_next;
            cnt_reg   <= cnt_next;
            key_reg   <= key_next;
            ptr_reg   <= ptr_next;
            memEn_reg <= memEn_next;
            guard_reg <= guard_next;
            reqT_reg  <= reqT_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            wr_reg    <= wr_next;
            io_reg    <= io_next;
            txV_reg   <= txV_next;
            txD_reg   <= txD_next;
        end
    end

    assign txValid   = txV_reg;
    assign txData    = txD_reg;
    assign guardTime = guard_reg;

    // ========================================
    // System side bus access
    // Address and data are held by the link side until the ack
    // toggle returns, so sampling them here is safe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ackT_reg  <= 1'b0;
            dsV_reg   <= 1'b0;
            dsW_reg   <= 1'b0;
            dsIo_reg  <= 1'b0;
            dsA_reg   <= 16'h0000;
            dsD_reg   <= 8'h00;
            rdata_reg <= 8'h00;
        end else if (dsV_reg && dsReady) begin
            dsV_reg   <= 1'b0;
            rdata_reg <= dsRdata;
            ackT_reg  <= ~ackT_reg;
        end else if (!dsV_reg && reqTSync != ackT_reg) begin
            dsV_reg  <= 1'b1;
            dsW_reg  <= wr_reg;
            dsIo_reg <= io_reg;
            dsA_reg  <= addr_reg;
            dsD_reg  <= wdata_reg;
        end
    end

    assign dsValid   = dsV_reg;
    assign dsWrite   = dsW_reg;
    assign dsIoSpace = dsIo_reg;
    assign dsAddr    = dsA_reg;
    assign dsWdata   = dsD_reg;

    // ========================================
    // Checks on the link side
    default clocking @(posedge linkClk); endclocking
    default disable iff (!linkRstN);

    wire logic inIdle = state_reg == spid_pkg::ST_IDLE && rxValid && !exc;
    wire logic inOpnd = state_reg == spid_pkg::ST_OPND && rxValid && !exc;
    wire logic busDone = state_reg == spid_pkg::ST_BUS && !pending && !exc;

    a_load_incr: assert property (busDone && op_reg == spid_pkg::OP_LOAD_INC
        |=> ptr_reg == $past(ptr_reg) + 16'h0001)
        else $error("load did not advance pointer");

    a_load_keep: assert property (busDone && isLoad(op_reg) && !op_reg[2]
        |=> $stable(ptr_reg))
        else $error("plain load moved pointer");

    a_read_return: assert property (busDone && !wr_reg
        |=> txValid && txData == $past(rdata_reg))
        else $error("read byte not returned");

    a_store_issue: assert property (inOpnd && isStore(op_reg)
        |=> wr_reg && addr_reg == $past(ptr_reg) && pending
            && wdata_reg == $past(rxData))
        else $error("store not issued at pointer");

    a_ptr_low: assert property (inOpnd && isPtrW(op_reg) && !op_reg[0]
        |=> ptr_reg[7:0] == $past(rxData)
            && $stable(ptr_reg[15:8]))
        else $error("pointer low byte not written");

    a_io_read: assert property (inIdle && isIoRd(rxData)
        |=> io_reg && !wr_reg && addr_reg == ioAddr($past(rxData)))
        else $error("io read address wrong");

    a_ctrl_read: assert property (inIdle && isCsRd(rxData)
        |=> txValid && txData == $past(cssRead))
        else $error("control space byte not returned");

    a_key_enable: assert property (state_reg == spid_pkg::ST_KEY && rxValid
        && !exc && cnt_reg == spid_pkg::KEY_LAST
        && keyShift == spid_pkg::KEY_VALUE |=> memEn_reg)
        else $error("valid key did not enable memory");

    a_enable_guard: assert property ($rose(memEn_reg)
        |-> $past(state_reg) == spid_pkg::ST_KEY)
        else $error("memory enabled outside key");

    a_enable_clear: assert property (inOpnd && isCsWr(op_reg)
        && op_reg[3:0] == spid_pkg::CSS_STATUS
        && !rxData[spid_pkg::MEMEN_BIT] |=> !memEn_reg)
        else $error("enable bit not cleared");

    a_error_enter: assert property (exc && state_reg != spid_pkg::ST_ERR
        |=> state_reg == spid_pkg::ST_ERR && !txValid)
        else $error("exception did not abort");

    a_error_hold: assert property (state_reg == spid_pkg::ST_ERR && !rxBreak
        |=> state_reg == spid_pkg::ST_ERR)
        else $error("left error state without break");

    c_key_ok: cover property (state_reg == spid_pkg::ST_KEY
        ##1 $rose(memEn_reg));
    c_load_inc: cover property (busDone
        && op_reg == spid_pkg::OP_LOAD_INC);
    c_recover: cover property (state_reg == spid_pkg::ST_ERR
        ##1 state_reg == spid_pkg::ST_IDLE);
    c_io_write: cover property (inOpnd && isIoWr(op_reg));

endmodule
`default_nettype wire

// ---- spid_pkg.sv ----
// Constants and types of the serial programming instruction decoder
//
// Summary of operation
// - Byte instructions; at most one operand, key takes eight
// - Indirect load: plain or post-increment pointer
// - Indirect load returns data-space byte at pointer
// - Indirect store writes operand at pointer
// - Pointer write; bit 0 picks byte
// - I/O read at six-bit direct address
// - I/O write at six-bit direct address
// - Control space read, four-bit address, returned
// - Control space write at four-bit address
// - Key command collects eight data bytes
// - Memory enable only after matching key
// - Writing zero clears memory enable
// - Read operands sent back; writes supplied
// - Exception aborts; error until break received with no bus access pending
package spid_pkg;

    // ========================================
    // Opcodes and decode masks
    localparam logic [7:0] OP_LOAD_INC  = 8'h24;
    localparam logic [7:0] OP_STORE_INC = 8'h64;
    localparam logic [7:0] OP_INC_BIT   = 8'h04;
    localparam logic [7:0] OP_PTR_ANY   = 8'h69;
    localparam logic [7:0] OP_PTR_BIT   = 8'h01;
    localparam logic [7:0] IO_MASK      = 8'h90;
    localparam logic [7:0] IO_RD        = 8'h10;
    localparam logic [7:0] IO_WR        = 8'h90;
    localparam logic [7:0] CS_MASK      = 8'hf0;
    localparam logic [7:0] CS_RD        = 8'h80;
    localparam logic [7:0] CS_WR        = 8'hc0;
    localparam logic [7:0] OP_KEY       = 8'he0;

    // ========================================
    // Control and status space
    localparam logic [3:0] CSS_STATUS   = 4'h0;
    localparam logic [3:0] CSS_PHYCTRL  = 4'h2;
    localparam logic [3:0] CSS_IDENT    = 4'hf;
    localparam int         MEMEN_BIT    = 1;
    localparam logic [2:0] GUARD_RST    = 3'h0;
    // Identification value is arbitrary
    localparam logic [7:0] IDENT_CODE   = 8'h5a;

    // ========================================
    // Key and reset values
    localparam logic [63:0] KEY_VALUE   = 64'h1289ab45cdd888ff;
    localparam logic [3:0]  KEY_LAST    = 4'h7;
    localparam logic [15:0] PTR_RST     = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPND = 3'b001,
        ST_KEY  = 3'b010,
        ST_BUS  = 3'b011,
        ST_SEND = 3'b100,
        ST_ERR  = 3'b101
    } spid_state_t;

endpackage

// ---- spid_sync.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module spid_sync (
    // Destination clock and synchronous reset
    input  wire logic clk,
    input  wire logic rstN,
    // Level in and out
    input  wire logic d,
    output logic      q
);

    logic meta_reg;
    logic sync_reg;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rstN) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule
`default_nettype wire

// ---- spid_prog_model.sv ----
// Behavioural model of the external programmer driving the link
`timescale 1ns/1ps
`default_nettype none
module spid_prog_model (
    // Link clock
    input  wire logic       linkClk,
    // Receive side seen by the decoder
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            rxBreak,
    output logic            rxFault,
    output logic            txCollision,
    // Transmit side seen by the decoder
    input  wire logic       txValid,
    output logic            txReady
);
    // Idle link at time zero
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        {rxBreak, rxFault, txCollision} = 3'h0;
    end

    // One byte a frame; released data shows the inverse, not a stale copy
    task automatic sendByte(input logic [7:0] b);
        @(negedge linkClk);
        rxValid = 1'b1;
        rxData = b;
        @(negedge linkClk);
        rxValid = 1'b0;
        rxData = ~b;
    endtask

    // Exception pulse: 0 break, 1 parity or frame fault, 2 collision
    task automatic sendExc(input int kind);
        @(negedge linkClk);
        rxBreak = (kind == 0);
        rxFault = (kind == 1);
        txCollision = (kind == 2);
        @(negedge linkClk);
        {rxBreak, rxFault, txCollision} = 3'h0;
    endtask

    // Takes returned bytes promptly or after a random stall
    always @(negedge linkClk) begin
        txReady <= txValid && !txReady && ($urandom % 3 == 0);
    end
endmodule
`default_nettype wire

// ---- test_serial_prog_instruction_decoder.sv ----
// Self-checking bench of the serial programming instruction decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_serial_prog_instruction_decoder;
    // ========================================
    // Clocks, ports and bench state
    logic        clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        nrst = 1'b0;
    logic        rxValid, rxBreak, rxFault, txCollision, txReady, txValid;
    logic [7:0]  rxData, txData, dsWdata, txExp;
    logic [2:0]  guardTime;
    logic        dsValid, dsWrite, dsIoSpace, nvmEnable;
    logic        dsReady = 1'b0;
    logic [7:0]  dsRdata = 8'h00;
    logic [15:0] dsAddr, ptr;
    logic [25:0] dsExp;
    logic [7:0]  mem [256];
    logic [7:0]  txQ [$];
    logic [25:0] dsQ [$];
    int          fails = 0;
    int          nCompared = 0;
    int          cycles = 0;

    always #5 clk = ~clk;
    // Link clock offset so its edges never meet the system clock's
    initial #3 forever #15 linkClk = ~linkClk;

    spid_decoder dut_u (.clk(clk), .nrst(nrst), .linkClk(linkClk),
        .rxValid(rxValid), .rxData(rxData), .rxBreak(rxBreak),
        .rxFault(rxFault), .txCollision(txCollision), .txValid(txValid),
        .txData(txData), .txReady(txReady), .guardTime(guardTime),
        .dsValid(dsValid), .dsWrite(dsWrite), .dsIoSpace(dsIoSpace),
        .dsAddr(dsAddr), .dsWdata(dsWdata), .dsReady(dsReady),
        .dsRdata(dsRdata), .nvmEnable(nvmEnable));
    spid_prog_model prog_u (.linkClk(linkClk), .rxValid(rxValid),
        .rxData(rxData), .rxBreak(rxBreak), .rxFault(rxFault),
        .txCollision(txCollision), .txValid(txValid), .txReady(txReady));

    // Data bus responder; random stalls, read data only valid while a request waits
    always @(negedge clk) begin
        dsReady <= dsValid && !dsReady && ($urandom % 2 == 0);
        dsRdata <= (dsValid && !dsReady) ? mem[dsAddr[7:0]] : ~dsRdata;
    end

    // ========================================
    // Watchers: oldest note is compared with each result
    always @(posedge clk) begin
        if (dsValid && dsReady) begin
            dsExp = dsQ.size() ? dsQ.pop_front() : 'x;
            `CHK({dsWrite, dsIoSpace, dsAddr, dsWrite ? dsWdata : 8'h00}, dsExp)
            if (dsWrite) mem[dsAddr[7:0]] <= dsWdata;
        end
    end
    always @(posedge linkClk) begin
        if (txValid && txReady) begin
            txExp = txQ.size() ? txQ.pop_front() : 'x;
            `CHK(txData, txExp)
        end
    end
    // Hang guard; the whole run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            finish_test();
        end
    end

    // ========================================
    // Message tasks
    task automatic waitTx();
        repeat (300) if (txQ.size() != 0) @(posedge linkClk);
        `CHK(txQ.size(), 0)
        repeat (3) @(posedge linkClk);
    endtask
    task automatic waitDs();
        repeat (300) if (dsQ.size() != 0) @(posedge linkClk);
        `CHK(dsQ.size(), 0)
        repeat (5) @(posedge linkClk);
    endtask
    task automatic csRead(input logic [3:0] a, input logic [7:0] e);
        txQ.push_back(e);
        prog_u.sendByte({4'h8, a});
        waitTx();
    endtask
    task automatic csWrite(input logic [3:0] a, input logic [7:0] d);
        prog_u.sendByte({4'hc, a});
        prog_u.sendByte(d);
        repeat (4) @(posedge linkClk);
    endtask
    task automatic setPtr(input logic [15:0] p);
        ptr = p;
        prog_u.sendByte(8'h68);
        prog_u.sendByte(p[7:0]);
        prog_u.sendByte(8'h69);
        prog_u.sendByte(p[15:8]);
        repeat (2) @(posedge linkClk);
    endtask
    task automatic dsStore(input logic [7:0] op, input logic [7:0] d);
        dsQ.push_back({2'b10, ptr, d});
        prog_u.sendByte(op);
        prog_u.sendByte(d);
        waitDs();
        if (op[2]) ptr++;
    endtask
    task automatic dsLoad(input logic [7:0] op);
        dsQ.push_back({2'b00, ptr, 8'h00});
        txQ.push_back(mem[ptr[7:0]]);
        prog_u.sendByte(op);
        waitTx();
        if (op[2]) ptr++;
    endtask
    task automatic sendKey(input logic [63:0] k);
        prog_u.sendByte(8'he0);
        for (int i = 0; i < 8; i++) prog_u.sendByte(k[8*i +: 8]);
        repeat (4) @(posedge linkClk);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        logic [7:0] d;
        logic [5:0] a;
        int seen;
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5c;
        void'($urandom(25866));
        repeat (15) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(posedge linkClk);
        `CHK(nvmEnable, 1'b0)
        csRead(4'h0, 8'h00);
        csRead(4'hf, spid_pkg::IDENT_CODE);
        csRead(4'h5, 8'h00);
        d = 8'($urandom);
        csWrite(4'h2, d);
        `CHK(guardTime, d[2:0])
        // Indirect access, both variants of load and store
        for (int i = 0; i < 2; i++) begin
            setPtr(16'($urandom));
            d = 8'($urandom);
            dsStore(spid_pkg::OP_STORE_INC, d);
            dsStore(8'h60, ~d);
            setPtr(ptr - 16'h0001);
            dsLoad(spid_pkg::OP_LOAD_INC);
            dsLoad(8'h20);
            dsLoad(8'h20);
        end
        // Direct I/O space, top address first
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 6'h3f : 6'($urandom);
            d = 8'($urandom);
            dsQ.push_back({2'b11, 10'h000, a, d});
            prog_u.sendByte({1'b1, a[5:4], 1'b1, a[3:0]});
            prog_u.sendByte(d);
            waitDs();
            dsQ.push_back({2'b01, 10'h000, a, 8'h00});
            txQ.push_back(d);
            prog_u.sendByte({1'b0, a[5:4], 1'b1, a[3:0]});
            waitTx();
        end
        // Key: a near miss leaves memory access shut
        sendKey(spid_pkg::KEY_VALUE ^ 64'h0000000000000100);
        `CHK(nvmEnable, 1'b0)
        csRead(4'h0, 8'h00);
        sendKey(spid_pkg::KEY_VALUE);
        for (seen = 0; seen < 200 && nvmEnable !== 1'b1; seen++) @(posedge clk);
        `CHK(nvmEnable, 1'b1)
        csRead(4'h0, 8'h02);
        csWrite(4'h0, 8'h00);
        repeat (10) @(posedge clk);
        `CHK(nvmEnable, 1'b0)
        csRead(4'h0, 8'h00);
        // Each exception kind in mid-message, then one break recovers
        for (int kd = 0; kd < 3; kd++) begin
            prog_u.sendByte(8'h68);
            prog_u.sendExc(kd);
            prog_u.sendByte(8'h80);
            seen = 0;
            repeat (20) @(posedge linkClk) seen += (txValid === 1'b1);
            `CHK(seen, 0)
            prog_u.sendExc(0);
            repeat (3) @(posedge linkClk);
            csRead(4'hf, spid_pkg::IDENT_CODE);
        end
        finish_test();
    end
endmodule
`default_nettype wire
